// file: bench/cef_event_flags_properties.sv
/* port checker for the event flag bank.
   assumes it is bound onto cef_event_flags, one clock domain */
`default_nettype none
module cef_event_flags_properties (
  input wire logic                 ref_clk_i,
  input wire logic                 rst_i,
  input wire cef_pkg::cef_status_s status_i,
  input wire cef_pkg::cef_mask_s   mask_i,
  input wire logic                 rd_req_i,
  input wire logic [7:0]           rd_addr_i,
  input wire logic [7:0]           rd_data_o,
  input wire logic                 rd_valid_o,
  input wire logic                 int_pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // a whole interrupt pulse, and the answer to a read of one address
  sequence s_pulse;
    int_pulse_o [*4];
  endsequence
  sequence s_answer(a);
    rd_valid_o && $past(rd_addr_i) == a;
  endsequence
  // read port timing
  AST_VALID_ONE: assert property (rd_valid_o |=> !rd_valid_o)
    else $error("read valid too long");
  AST_TAKE: assert property (rd_req_i && !rd_valid_o |=> rd_valid_o)
    else $error("read not answered");
  // reserved bits, unmapped reads and the detect flag while busy give zero
  AST_RSV_TWO: assert property (s_answer(8'h24) |-> !rd_data_o[7])
    else $error("reserved bit set");
  AST_RSV_THREE: assert property (s_answer(8'h25) |-> rd_data_o[7:5] == 3'h0)
    else $error("reserved bits set");
  AST_RSV_FAULT: assert property (s_answer(8'h26) |-> rd_data_o[1:0] == 2'h0)
    else $error("reserved bits set");
  AST_UNMAPPED: assert property (s_answer(8'h27) |-> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  AST_BUSY: assert property (s_answer(8'h24) ##0 $past(status_i.dpdm_busy, 2) |-> !rd_data_o[6])
    else $error("detect flag set while busy");
  // unmasked events pulse the interrupt; reset edge guarded for level changes
  AST_FAST: assert property ($rose(status_i.fast_tmr_exp) && !mask_i.flags_two[3] |=> s_pulse)
    else $error("no pulse on fast timeout");
  AST_MINSYS: assert property (!$past(rst_i) && $fell(status_i.min_sys_reg)
    && !mask_i.flags_two[4] |=> s_pulse)
    else $error("no pulse on regulation exit");
  AST_IBAT: assert property (!$past(rst_i) && $changed(status_i.batt_current_reg)
    && !mask_i.fault_zero[7] |=> s_pulse)
    else $error("no pulse on current regulation change");
endmodule // cef_event_flags_properties
bind cef_event_flags cef_event_flags_properties u_cef_event_flags_properties (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .status_i(status_i), .mask_i(mask_i), .rd_req_i(rd_req_i),
  .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .int_pulse_o(int_pulse_o));
`default_nettype wire

// file: bench/cef_host_model.sv
/* host side of the register read port: one request cycle per go.
   assumes go_i is driven on the rising edge of clk_i */
`default_nettype none
module cef_host_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [7:0] addr_i,
  output logic            rd_req_o,
  output logic      [7:0] rd_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle address toggles so a stale value never looks like a request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_req_o  <= 1'b0;
      rd_addr_o <= 8'h00;
    end else begin
      rd_req_o  <= go_i;
      rd_addr_o <= go_i ? addr_i : ~rd_addr_o;
    end
  end
endmodule // cef_host_model
`default_nettype wire

// file: bench/test_cef_event_flags.sv
/* self-checking bench of the event flag bank.
   assumes the host model and the bound checker beside it */
`default_nettype none
module test_cef_event_flags;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 ref_clk_i;
  logic                 rst_i;
  logic                 go;
  logic                 rd_req;
  logic                 rd_valid;
  logic                 int_pulse;
  logic [7:0]           addr;
  logic [7:0]           rd_addr;
  logic [7:0]           rd_data;
  cef_pkg::cef_status_s status;
  cef_pkg::cef_mask_s   mask;
  logic [7:0]           exp_q[$];
  int                   errors;
  int                   compares;
  int                   cycles;
  int                   seed;
  int                   p;

  cef_host_model u_cef_host_model (.clk_i(ref_clk_i), .rst_i(rst_i), .go_i(go), .addr_i(addr),
    .rd_req_o(rd_req), .rd_addr_o(rd_addr));
  cef_event_flags u_cef_event_flags (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .status_i(status), .mask_i(mask),
    .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .int_pulse_o(int_pulse));

  // 40 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // note the expected byte, then one read; gap keeps reads apart
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask

  // oldest note against each answered byte; empty queue expects x and fails
  always @(posedge ref_clk_i) begin
    if (rd_valid === 1'b1)
      check("read data", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rd_data);
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    seed = 90;
    rst_i = 1'b1;
    go = 1'b0;
    addr = 8'h00;
    status = '0;
    mask = '0;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // all three registers and one unmapped place read zero
    for (int a = 0; a < 4; a++) rd(8'h24 + 8'(a), 8'h00);
    status.adc_one_shot <= 1'b1;
    // one source at a time: set, read, read again cleared, drop
    for (int i = 0; i < 19; i++) begin
      if (i == 16) continue;
      p = i < 6 ? 18 + i : i < 11 ? i + 2 : i < 16 ? i - 11 : i - 12;
      status[i] <= 1'b1;
      mask <= 24'($random(seed));
      repeat (2) @(posedge ref_clk_i);
      #1 check("interrupt", 8'(!mask[p]), 8'(int_pulse));
      rd(8'h24 + 8'(p / 8), 8'h01 << (p % 8));
      rd(8'h24 + 8'(p / 8), 8'h00);
      status[i] <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rd(8'h24 + 8'(p / 8), (i == 5 || i == 15) ? 8'h01 << (p % 8) : 8'h00);
    end
    // conversion outside one-shot mode is not flagged
    status.adc_one_shot <= 1'b0;
    status.adc_done <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rd(8'h24, 8'h00);
    // detection done while still busy is not flagged
    status.dpdm_busy <= 1'b1;
    status.dpdm_done <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rd(8'h24, 8'h00);
    // unmapped read leaves a pending flag alone
    status.bus_ov <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rd(8'h27, 8'h00);
    rd(8'h26, 8'h40);
    repeat (4) @(posedge ref_clk_i);
    check("pending reads", 8'h00, 8'(exp_q.size()));
    give_verdict();
  end
endmodule // test_cef_event_flags
`default_nettype wire

// file: logic/cef_defines.svh
/*
  Offsets, field positions, reserved masks and timing counts of the charger
  event flag bank.
  Assumes a 40 MHz ref_clk_i; included by bare name from the design only.
*/
`ifndef CEF_DEFINES_SVH
`define CEF_DEFINES_SVH

// register offsets on the serial control port
`define CEF_OFS_FLAGS_TWO      8'h24
`define CEF_OFS_FLAGS_THREE    8'h25
`define CEF_OFS_FAULT_ZERO     8'h26

// byte lanes of the internal 24-bit flag vector
`define CEF_LANE_TWO           0
`define CEF_LANE_THREE         1
`define CEF_LANE_FAULT         2

// charger event flags two
`define CEF_F2_DPDM_DONE       6
`define CEF_F2_ADC_DONE        5
`define CEF_F2_MIN_SYS         4
`define CEF_F2_FAST_TMR        3
`define CEF_F2_TRICKLE_TMR     2
`define CEF_F2_PRE_TMR         1
`define CEF_F2_TOPOFF_TMR      0

// charger event flags three
`define CEF_F3_BATT_LOW_OUT    4
`define CEF_F3_TS_COLD         3
`define CEF_F3_TS_COOL         2
`define CEF_F3_TS_WARM         1
`define CEF_F3_TS_HOT          0

// protection fault flags zero
`define CEF_FF_IBAT_REG        7
`define CEF_FF_BUS_OV          6
`define CEF_FF_BATT_OV         5
`define CEF_FF_INPUT_OC        4
`define CEF_FF_DISCH_OC        3
`define CEF_FF_CONV_OC         2

// implemented bits per register, the rest read as zero
`define CEF_IMPL_TWO           8'h7f
`define CEF_IMPL_THREE         8'h1f
`define CEF_IMPL_FAULT         8'hfc
`define CEF_RESET_FLAGS        8'h00

// bits that flag on both edges of their status level
`define CEF_ANY_TWO            8'h10
`define CEF_ANY_THREE          8'h00
`define CEF_ANY_FAULT          8'h80

// interrupt pulse timing
`define CEF_CLK_PERIOD_NS      25
`define CEF_INT_PULSE_NS       100
`define CEF_INT_PULSE_CYC      ((`CEF_INT_PULSE_NS + `CEF_CLK_PERIOD_NS - 1) / `CEF_CLK_PERIOD_NS)

`endif

// file: logic/cef_edge_det.sv
/*
  Per-bit edge detector: rising edge, or any change where any_i is set.
  Assumes levels synchronous to clk_i; output is combinational from one flop.
*/
`default_nettype none

module cef_edge_det #(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // levels and per-bit mode
  input  wire logic [W-1:0] lvl_i,
  input  wire logic [W-1:0] any_i,
  // one-cycle events
  output logic      [W-1:0] evt_o
);

  logic [W-1:0] prev_reg;

  // previous level; zero at reset so a level already high flags once
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= lvl_i;
    end
  end

  // rising edge, or either edge for transition-type flags
  assign evt_o = (any_i & (lvl_i ^ prev_reg)) | (~any_i & lvl_i & ~prev_reg);

endmodule // cef_edge_det

`default_nettype wire

// file: logic/cef_event_flags.sv
/*
  Charger event flag bank: three read-only, clear-on-read flag registers
  fed by charger status levels, with a masked interrupt pulse.
  Assumes the serial control port decodes its frames elsewhere and presents
  single-byte reads here; mask bytes come from the mask registers outside.
*/
`default_nettype none

`include "cef_defines.svh"

//
// Contract
// - data-line detect done flag bit 6 sets on completion, zero while running.
// - conversion done flag bit 5 sets on conversion end, one-shot mode only.
// - minimum-system flag bit 4 sets on entering or leaving that regulation.
// - fast-charge timeout flag bit 3 sets on expiry rising edge.
// - trickle-charge timeout flag bit 2 sets on expiry rising edge.
// - pre-charge timeout flag bit 1 sets on expiry rising edge.
// - top-off timeout flag bit 0 sets on expiry rising edge.
// - battery-too-low flag bit 4 of third register sets when battery falls low.
// - thermistor cold flag bit 3 sets on crossing cold threshold.
// - thermistor cool flag bit 2 sets on crossing cool threshold.
// - thermistor warm flag bit 1 sets on crossing warm threshold.
// - thermistor hot flag bit 0 sets on crossing hot threshold.
// - battery current regulation fault bit 7 sets on entry and exit.
// - fault bits 6,5,4,2 set on entering bus OV, battery OV, input OC, converter OC.
// - discharge over-current fault bit 3 sets on entering that protection.
// - each flag event pulses the interrupt unless its mask bit is one.
module cef_event_flags (
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  // charger status levels and mask bytes
  input  wire cef_pkg::cef_status_s status_i,
  input  wire cef_pkg::cef_mask_s   mask_i,
  // register read port
  input  wire logic                 rd_req_i,
  input  wire logic [7:0]           rd_addr_i,
  output logic      [7:0]           rd_data_o,
  output logic                      rd_valid_o,
  // interrupt
  output logic                      int_pulse_o
);

  localparam logic [3:0] PULSE_CYC = 4'(`CEF_INT_PULSE_CYC);

  // position of a flag in the 24-bit vector
  function automatic int flag_idx(input int lane, input int bit_pos);
    flag_idx = lane * 8 + bit_pos;
  endfunction

  // one-hot lane select of a register address, zero when unmapped
  function automatic logic [2:0] lane_sel(input logic [7:0] addr);
    if (addr == `CEF_OFS_FLAGS_TWO) begin
      lane_sel = 3'h1;
    end else if (addr == `CEF_OFS_FLAGS_THREE) begin
      lane_sel = 3'h2;
    end else if (addr == `CEF_OFS_FAULT_ZERO) begin
      lane_sel = 3'h4;
    end else begin
      lane_sel = 3'h0;
    end
  endfunction

  localparam int IDX_DPDM = flag_idx(`CEF_LANE_TWO, `CEF_F2_DPDM_DONE);
  localparam int IDX_ADC  = flag_idx(`CEF_LANE_TWO, `CEF_F2_ADC_DONE);

  logic [23:0]            lvl_vec;
  logic [23:0]            any_vec;
  logic [23:0]            edge_evt;
  logic [23:0]            impl_vec;
  logic [23:0]            set_vec;
  logic [23:0]            clr_vec;
  logic [23:0]            flags_reg;
  logic [23:0]            flags_next;
  logic [2:0]             sel;
  logic [7:0]             rd_byte;
  logic                   rd_take;
  logic                   new_evt;
  logic [3:0]             pulse_cnt_reg;
  cef_pkg::cef_rd_state_e rd_state_reg;
  cef_pkg::cef_rd_state_e rd_state_next;

  // status levels placed at their flag positions
  always_comb begin
    lvl_vec = '0;
    lvl_vec[IDX_DPDM] = status_i.dpdm_done;
    lvl_vec[IDX_ADC]  = status_i.adc_done;
    lvl_vec[flag_idx(`CEF_LANE_TWO, `CEF_F2_MIN_SYS)]       = status_i.min_sys_reg;
    lvl_vec[flag_idx(`CEF_LANE_TWO, `CEF_F2_FAST_TMR)]      = status_i.fast_tmr_exp;
    lvl_vec[flag_idx(`CEF_LANE_TWO, `CEF_F2_TRICKLE_TMR)]   = status_i.trickle_tmr_exp;
    lvl_vec[flag_idx(`CEF_LANE_TWO, `CEF_F2_PRE_TMR)]       = status_i.pre_tmr_exp;
    lvl_vec[flag_idx(`CEF_LANE_TWO, `CEF_F2_TOPOFF_TMR)]    = status_i.topoff_tmr_exp;
    lvl_vec[flag_idx(`CEF_LANE_THREE, `CEF_F3_BATT_LOW_OUT)] = status_i.batt_low_power_out;
    lvl_vec[flag_idx(`CEF_LANE_THREE, `CEF_F3_TS_COLD)]     = status_i.ts_cold;
    lvl_vec[flag_idx(`CEF_LANE_THREE, `CEF_F3_TS_COOL)]     = status_i.ts_cool;
    lvl_vec[flag_idx(`CEF_LANE_THREE, `CEF_F3_TS_WARM)]     = status_i.ts_warm;
    lvl_vec[flag_idx(`CEF_LANE_THREE, `CEF_F3_TS_HOT)]      = status_i.ts_hot;
    lvl_vec[flag_idx(`CEF_LANE_FAULT, `CEF_FF_IBAT_REG)]    = status_i.batt_current_reg;
    lvl_vec[flag_idx(`CEF_LANE_FAULT, `CEF_FF_BUS_OV)]      = status_i.bus_ov;
    lvl_vec[flag_idx(`CEF_LANE_FAULT, `CEF_FF_BATT_OV)]     = status_i.batt_ov;
    lvl_vec[flag_idx(`CEF_LANE_FAULT, `CEF_FF_INPUT_OC)]    = status_i.input_oc;
    lvl_vec[flag_idx(`CEF_LANE_FAULT, `CEF_FF_CONV_OC)]     = status_i.conv_oc;
    lvl_vec[flag_idx(`CEF_LANE_FAULT, `CEF_FF_DISCH_OC)]    = status_i.discharge_oc;
  end

  // transition-type flags fire on both edges
  assign any_vec  = {`CEF_ANY_FAULT, `CEF_ANY_THREE, `CEF_ANY_TWO};
  assign impl_vec = {`CEF_IMPL_FAULT, `CEF_IMPL_THREE, `CEF_IMPL_TWO};

  cef_edge_det #(
    .W (24)
  ) u_edge (
    .clk_i (ref_clk_i),
    .rst_i (rst_i),
    .lvl_i (lvl_vec),
    .any_i (any_vec),
    .evt_o (edge_evt)
  );

  // qualified set events; detection restart suppresses the done flag
  always_comb begin
    set_vec = edge_evt & impl_vec;
    set_vec[IDX_ADC] = edge_evt[IDX_ADC] & status_i.adc_one_shot;
    if (status_i.dpdm_busy) begin
      set_vec[IDX_DPDM] = 1'b0;
    end
  end

  // read request decode; only taken while idle
  assign sel     = lane_sel(rd_addr_i);
  assign rd_take = rd_req_i && (rd_state_reg == cef_pkg::CEF_RD_IDLE);

  // clear only the bits handed to the host, so a later event is kept
  always_comb begin
    clr_vec = '0;
    rd_byte = 8'h00;
    if (rd_take) begin
      if (sel[0]) begin
        rd_byte = flags_reg[7:0];
      end else if (sel[1]) begin
        rd_byte = flags_reg[15:8];
      end else if (sel[2]) begin
        rd_byte = flags_reg[23:16];
      end
      clr_vec = {sel[2] ? rd_byte : 8'h00, sel[1] ? rd_byte : 8'h00, sel[0] ? rd_byte : 8'h00};
    end
  end

  // set wins over the clear of the same cycle
  always_comb begin
    flags_next = ((flags_reg & ~clr_vec) | set_vec) & impl_vec;
    if (status_i.dpdm_busy) begin
      flags_next[IDX_DPDM] = 1'b0;
    end
  end

  // flag storage, all clear at power-on
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_reg <= {3{`CEF_RESET_FLAGS}};
    end else begin
      flags_reg <= flags_next;
    end
  end

  // read port sequencing
  always_comb begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      cef_pkg::CEF_RD_IDLE: begin
        if (rd_req_i) begin
          rd_state_next = cef_pkg::CEF_RD_ANSWER;
        end
      end
      cef_pkg::CEF_RD_ANSWER: begin
        rd_state_next = cef_pkg::CEF_RD_IDLE;
      end
      default: begin
        rd_state_next = cef_pkg::CEF_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_state_reg <= cef_pkg::CEF_RD_IDLE;
    end else begin
      rd_state_reg <= rd_state_next;
    end
  end

  // read answer; data holds until the next accepted read
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_take;
      if (rd_take) begin
        rd_data_o <= rd_byte; // unmapped address answers zero
      end
    end
  end

  // any unmasked new event starts or restarts the pulse
  assign new_evt = |(set_vec & ~mask_i);

  // fixed-width pulse; back-to-back events merge into one longer pulse
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_cnt_reg <= 4'h0;
      int_pulse_o   <= 1'b0;
    end else if (new_evt) begin
      pulse_cnt_reg <= PULSE_CYC;
      int_pulse_o   <= 1'b1;
    end else if (pulse_cnt_reg > 4'h1) begin
      pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
      int_pulse_o   <= 1'b1;
    end else begin
      pulse_cnt_reg <= 4'h0;
      int_pulse_o   <= 1'b0;
    end
  end

endmodule // cef_event_flags

`default_nettype wire

// file: logic/cef_pkg.sv
/*
  Types of the charger event flag bank: status carrier, mask carrier and the
  read-port state machine encoding.
  Needs nothing from cef_defines.svh; its encodings are written in place.
*/
`default_nettype none

package cef_pkg;

  // status levels from the charger core, all active high
  typedef struct packed {
    logic dpdm_busy;
    logic dpdm_done;
    logic adc_done;
    logic adc_one_shot;
    logic min_sys_reg;
    logic fast_tmr_exp;
    logic trickle_tmr_exp;
    logic pre_tmr_exp;
    logic topoff_tmr_exp;
    logic batt_low_power_out;
    logic ts_cold;
    logic ts_cool;
    logic ts_warm;
    logic ts_hot;
    logic batt_current_reg;
    logic bus_ov;
    logic batt_ov;
    logic input_oc;
    logic discharge_oc;
    logic conv_oc;
  } cef_status_s;

  // mask bytes, bit for bit aligned with the flag registers
  typedef struct packed {
    logic [7:0] fault_zero;
    logic [7:0] flags_three;
    logic [7:0] flags_two;
  } cef_mask_s;

  // read-port state, one-hot
  typedef enum logic [1:0] {
    CEF_RD_IDLE   = 2'b01,
    CEF_RD_ANSWER = 2'b10
  } cef_rd_state_e;

endpackage : cef_pkg

`default_nettype wire
